// ==== rtl/dsw_serial_write.v ====
`timescale 1ns/1ns
`include "dsw_consts.vh"
// Operation
// - select falling powers input buffers and arms the shift register for a frame
// - host gives one bit per shift clock; device takes the next 24 falling edges
// - select rising before the 24th falling edge discards the partial frame and pulses frame_abort_ff
// - data input is sampled on each of the first 24 falling shift clock edges after select falls
// - the input shift register is 24 bits and holds one whole frame
// - reference pin is an input after reset; driven only with internal reference selected
module dsw_serial_write #(
  parameter FRAME_BITS = `DSW_FRAME_BITS
) (
  input wire mclk,
  input wire rst,
  input wire frame_select_n,
  input wire shift_clock,
  input wire serial_data_in,
  input wire int_ref_select,
  input wire ref_level_out,
  output reg ref_pin_out_ff,
  output reg ref_pin_oe_ff,
  output reg buffers_on_ff,
  output reg [FRAME_BITS-1:0] frame_word_ff,
  output reg frame_valid_ff,
  output reg frame_abort_ff
);
  // ****************************************
  // derived constants
  // ****************************************
  // last count of a frame; the bit counter starts from zero at the select fall
  localparam [`DSW_CNT_W-1:0] LAST_CNT = FRAME_BITS[`DSW_CNT_W-1:0] - 5'h01;

  // ****************************************
  // input synchronisers
  // ****************************************
  // mclk of 8 ns resolves shift clock only at slow link rates; each clock phase
  // needs three mclk, so above about 20 MHz the host must slow down
  wire sel_n_s;
  wire sclk_s;
  wire din_s;
  dsw_sync3 #(
    .RST_VAL(1'b1)
  ) u_sel (
    .mclk(mclk),
    .rst(rst),
    .din(frame_select_n),
    .dout_ff(sel_n_s)
  );
  dsw_sync3 #(
    .RST_VAL(1'b1)
  ) u_sclk (
    .mclk(mclk),
    .rst(rst),
    .din(shift_clock),
    .dout_ff(sclk_s)
  );
  dsw_sync3 #(
    .RST_VAL(1'b0)
  ) u_din (
    .mclk(mclk),
    .rst(rst),
    .din(serial_data_in),
    .dout_ff(din_s)
  );

  // ****************************************
  // edge helpers
  // ****************************************
  // edges are taken between the last settled level and the one before it
  function is_fall;
    input prev_lvl;
    input cur_lvl;
    begin
      is_fall = prev_lvl & ~cur_lvl;
    end
  endfunction

  function is_rise;
    input prev_lvl;
    input cur_lvl;
    begin
      is_rise = ~prev_lvl & cur_lvl;
    end
  endfunction

  reg sel_n_d_ff;
  reg sclk_d_ff;
  wire sel_fall = is_fall(sel_n_d_ff, sel_n_s);
  wire sel_rise = is_rise(sel_n_d_ff, sel_n_s);
  wire sclk_fall = is_fall(sclk_d_ff, sclk_s);

  // ****************************************
  // frame state machine
  // ****************************************
  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [`DSW_CNT_W-1:0] cnt_ff;
  reg [`DSW_CNT_W-1:0] nxt_cnt;
  reg [FRAME_BITS-1:0] shift_ff;
  reg [FRAME_BITS-1:0] nxt_shift;
  reg nxt_valid;
  reg nxt_abort;
  reg [FRAME_BITS-1:0] nxt_word;

  always @*
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_shift = shift_ff;
    nxt_valid = 1'b0;
    nxt_abort = 1'b0;
    nxt_word = frame_word_ff;
    case (state_ff)
      `DSW_ST_IDLE:
      begin
        if (sel_fall)
        begin
          nxt_state = `DSW_ST_SHIFT;
          nxt_cnt = {`DSW_CNT_W{1'b0}};
        end
      end
      `DSW_ST_SHIFT:
      begin
        if (sel_rise)
        begin
          // partial frame dropped; word output untouched
          nxt_state = `DSW_ST_IDLE;
          nxt_abort = 1'b1;
        end
        else if (sclk_fall)
        begin
          nxt_shift = {shift_ff[FRAME_BITS-2:0], din_s};
          if (cnt_ff == LAST_CNT)
          begin
            nxt_word = {shift_ff[FRAME_BITS-2:0], din_s};
            nxt_valid = 1'b1;
            nxt_state = `DSW_ST_DONE;
          end
          else
            nxt_cnt = cnt_ff + 5'h01;
        end
      end
      `DSW_ST_DONE:
      begin
        // extra edges ignored until select returns high
        if (sel_rise)
          nxt_state = `DSW_ST_IDLE;
      end
      default:
        nxt_state = `DSW_ST_IDLE;
    endcase
  end

  // ****************************************
  // edge history
  // ****************************************
  // reset to the idle pin levels so that leaving reset shows no false edge
  always @(posedge mclk)
  begin
    if (rst)
    begin
      sel_n_d_ff <= 1'b1;
      sclk_d_ff <= 1'b1;
    end
    else
    begin
      sel_n_d_ff <= sel_n_s;
      sclk_d_ff <= sclk_s;
    end
  end

  // ****************************************
  // frame registers
  // ****************************************
  always @(posedge mclk)
  begin
    if (rst)
    begin
      state_ff <= `DSW_ST_IDLE;
      cnt_ff <= {`DSW_CNT_W{1'b0}};
      shift_ff <= {FRAME_BITS{1'b0}};
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      shift_ff <= nxt_shift;
    end
  end

  // ****************************************
  // frame outputs
  // ****************************************
  // the word moves only with the valid pulse, so a reader may take it on that pulse
  always @(posedge mclk)
  begin
    if (rst)
    begin
      frame_word_ff <= {FRAME_BITS{1'b0}};
      frame_valid_ff <= 1'b0;
      frame_abort_ff <= 1'b0;
      buffers_on_ff <= 1'b0;
    end
    else
    begin
      frame_word_ff <= nxt_word;
      frame_valid_ff <= nxt_valid;
      frame_abort_ff <= nxt_abort;
      buffers_on_ff <= ~sel_n_s;
    end
  end

  // ****************************************
  // reference pin direction
  // ****************************************
  // pin stays an input until the internal reference is chosen
  always @(posedge mclk)
  begin
    if (rst)
    begin
      ref_pin_oe_ff <= 1'b0;
      ref_pin_out_ff <= 1'b0;
    end
    else
    begin
      ref_pin_oe_ff <= int_ref_select;
      ref_pin_out_ff <= int_ref_select & ref_level_out;
    end
  end
endmodule

// ==== rtl/dsw_consts.vh ====
`ifndef DSW_CONSTS_VH
`define DSW_CONSTS_VH
// frame length in falling shift clock edges
`define DSW_FRAME_BITS 24
`define DSW_CNT_W 5
// shortest host shift clock period, ns (50 MHz)
`define DSW_SCLK_MIN_NS 20
`define DSW_MCLK_NS 8
// frame states
`define DSW_ST_IDLE 2'h0
`define DSW_ST_SHIFT 2'h1
`define DSW_ST_DONE 2'h2
`endif

// ==== rtl/dsw_sync3.v ====
`timescale 1ns/1ns
// three-stage synchroniser; the level changes once stages two and three agree
module dsw_sync3 #(
  parameter RST_VAL = 1'b0
) (
  input wire mclk,
  input wire rst,
  input wire din,
  output reg dout_ff
);
  reg s1_ff;
  reg s2_ff;
  reg s3_ff;
  always @(posedge mclk)
  begin
    if (rst)
    begin
      s1_ff <= RST_VAL;
      s2_ff <= RST_VAL;
      s3_ff <= RST_VAL;
      dout_ff <= RST_VAL;
    end
    else
    begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff)
        dout_ff <= s3_ff;
    end
  end
endmodule

// ==== testbench/dsw_sva.sv ====
`timescale 1ns/1ns
module dsw_sva #(
  parameter FRAME_BITS = 24
) (
  input wire mclk,
  input wire rst,
  input wire frame_select_n,
  input wire shift_clock,
  input wire serial_data_in,
  input wire int_ref_select,
  input wire ref_level_out,
  input wire ref_pin_out_ff,
  input wire ref_pin_oe_ff,
  input wire buffers_on_ff,
  input wire [FRAME_BITS-1:0] frame_word_ff,
  input wire frame_valid_ff,
  input wire frame_abort_ff
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  chk_buf_on: assert property ($fell(frame_select_n) |-> ##[3:7] buffers_on_ff)
    else $error("buf late");
  chk_buf_idle: assert property (frame_select_n [*8] |-> !buffers_on_ff)
    else $error("buf on");
  chk_valid_one: assert property (frame_valid_ff |=> !frame_valid_ff)
    else $error("valid long");
  chk_abort_one: assert property (frame_abort_ff |=> !frame_abort_ff)
    else $error("abort long");
  chk_valid_live: assert property (frame_valid_ff |-> buffers_on_ff && !frame_abort_ff)
    else $error("valid idle");
  chk_word_hold: assert property (!frame_valid_ff |-> $stable(frame_word_ff))
    else $error("word moved");
  chk_ref_drive: assert property (!$past(rst) |-> ref_pin_oe_ff == $past(int_ref_select))
    else $error("ref oe");
  chk_ref_level: assert property (!$past(rst) |-> ref_pin_out_ff == $past(int_ref_select & ref_level_out))
    else $error("ref out");
  cover property (frame_valid_ff);
  cover property (frame_abort_ff);
  cover property (ref_pin_oe_ff);
endmodule
bind dsw_serial_write dsw_sva #(.FRAME_BITS(FRAME_BITS)) i_dsw_sva (
  .mclk(mclk),
  .rst(rst),
  .frame_select_n(frame_select_n),
  .shift_clock(shift_clock),
  .serial_data_in(serial_data_in),
  .int_ref_select(int_ref_select),
  .ref_level_out(ref_level_out),
  .ref_pin_out_ff(ref_pin_out_ff),
  .ref_pin_oe_ff(ref_pin_oe_ff),
  .buffers_on_ff(buffers_on_ff),
  .frame_word_ff(frame_word_ff),
  .frame_valid_ff(frame_valid_ff),
  .frame_abort_ff(frame_abort_ff)
);

// ==== testbench/dsw_host.sv ====
`timescale 1ns/1ns
module dsw_host (
  input wire mclk,
  output reg frame_select_n = 1'b1,
  output reg shift_clock = 1'b1,
  output reg serial_data_in = 1'b0
);
  // 10 mclk per bit keeps the link clock at 80 ns, far below 50 MHz
  task send(input [31:0] w, input integer n);
    integer i;
    begin
      @(negedge mclk) frame_select_n <= 1'b0;
      for (i = n - 1; i >= 0; i = i - 1)
      begin
        serial_data_in <= w[i];
        repeat (5) @(negedge mclk);
        shift_clock <= 1'b0;
        repeat (5) @(negedge mclk);
        shift_clock <= 1'b1;
      end
      serial_data_in <= ~serial_data_in;
      repeat (5) @(negedge mclk);
      frame_select_n <= 1'b1;
      repeat (9) @(negedge mclk);
    end
  endtask
endmodule

// ==== testbench/test_dsw_serial_write.sv ====
`timescale 1ns/1ns
module test_dsw_serial_write;
  reg mclk = 1'b0;
  reg rst = 1'b1;
  reg int_ref_select = 1'b0;
  reg ref_level_out = 1'b1;
  wire frame_select_n, shift_clock, serial_data_in, ref_pin_out_ff, ref_pin_oe_ff;
  wire buffers_on_ff, frame_valid_ff, frame_abort_ff;
  wire [23:0] frame_word_ff;
  integer fail_count = 0, n_tests = 0, nv = 0, na = 0;
  dsw_serial_write i_dsw_serial_write (
    .mclk(mclk),
    .rst(rst),
    .frame_select_n(frame_select_n),
    .shift_clock(shift_clock),
    .serial_data_in(serial_data_in),
    .int_ref_select(int_ref_select),
    .ref_level_out(ref_level_out),
    .ref_pin_out_ff(ref_pin_out_ff),
    .ref_pin_oe_ff(ref_pin_oe_ff),
    .buffers_on_ff(buffers_on_ff),
    .frame_word_ff(frame_word_ff),
    .frame_valid_ff(frame_valid_ff),
    .frame_abort_ff(frame_abort_ff)
  );
  dsw_host i_dsw_host (
    .mclk(mclk),
    .frame_select_n(frame_select_n),
    .shift_clock(shift_clock),
    .serial_data_in(serial_data_in)
  );
  initial
    forever #4 mclk = ~mclk;
  always @(posedge mclk)
  begin
    nv <= rst ? 0 : nv + (frame_valid_ff !== 1'b0);
    na <= rst ? 0 : na + (frame_abort_ff !== 1'b0);
  end
  task chk(input [23:0] g, input [23:0] e);
    begin
      n_tests = n_tests + 1;
      if (g !== e)
      begin
        fail_count = fail_count + 1;
        $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task frm(input [31:0] w, input integer n, input [23:0] ew, input integer dv, input integer da);
    integer v, a;
    begin
      v = nv;
      a = na;
      i_dsw_host.send(w, n);
      chk(frame_word_ff, ew);
      chk(nv - v, dv);
      chk(na - a, da);
      chk(buffers_on_ff, 1'b0);
    end
  endtask
  task t_ref;
    begin
      chk({frame_word_ff[0], ref_pin_oe_ff, ref_pin_out_ff}, 24'h0);
      int_ref_select = 1'b1;
      repeat (2) @(negedge mclk);
      chk({ref_pin_oe_ff, ref_pin_out_ff}, 24'h3);
      ref_level_out = 1'b0;
      repeat (2) @(negedge mclk);
      chk({ref_pin_oe_ff, ref_pin_out_ff}, 24'h2);
      int_ref_select = 1'b0;
      ref_level_out = 1'b1;
      repeat (2) @(negedge mclk);
      chk({ref_pin_oe_ff, ref_pin_out_ff}, 24'h0);
    end
  endtask
  task t_full;
    begin
      frm(32'h00A5C30F, 24, 24'hA5C30F, 1, 0);
      frm(32'h005A3CF0, 24, 24'h5A3CF0, 1, 0);
    end
  endtask
  task t_abort;
    begin
      frm(32'h007FFFFF, 23, 24'h5A3CF0, 0, 1);
      frm(32'h00000001, 1, 24'h5A3CF0, 0, 1);
    end
  endtask
  task t_overrun;
    begin
      frm(32'h03C3C3C3, 26, 24'hF0F0F0, 1, 0);
    end
  endtask
  task t_reset;
    begin
      int_ref_select = 1'b1;
      rst = 1'b1;
      repeat (16) @(negedge mclk);
      chk({ref_pin_oe_ff, ref_pin_out_ff}, 24'h0);
      int_ref_select = 1'b0;
      rst = 1'b0;
      repeat (4) @(negedge mclk);
      chk({ref_pin_oe_ff, buffers_on_ff}, 24'h0);
      frm(32'h00C0FFEE, 24, 24'hC0FFEE, 1, 0);
    end
  endtask
  task end_sim;
    begin
      if (fail_count == 0 && n_tests > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  initial
  begin
    repeat (16) @(negedge mclk);
    rst = 1'b0;
    repeat (4) @(negedge mclk);
    t_ref;
    t_full;
    t_abort;
    t_overrun;
    t_reset;
    end_sim;
  end
endmodule
